/* hw/wdt_map.svh */
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ---------------------------------------------------------------------------
// Register offsets and fields
// ---------------------------------------------------------------------------
`define WDT_CTRL_OFFSET      8'h00
`define WDT_STAT_OFFSET      8'h04
`define WDT_ENABLE_BIT       0
`define WDT_PERIOD_LSB       1
`define WDT_PERIOD_MSB       5
`define WDT_CTRL_RESET       8'h16
`define WDT_PERIOD_RESET     5'h0b

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define WDT_CLK_HZ           200000000
`define WDT_LFOSC_HZ         31000
`define WDT_TICK_US          1000
`define WDT_LFOSC_PER_TICK   ((`WDT_LFOSC_HZ * `WDT_TICK_US) / 1000000)

`endif

/* hw/wdt_pkg.sv */
package wdt_pkg;
  typedef enum logic [1:0] {
    MODE_OFF      = 2'b00,
    MODE_SOFTWARE = 2'b01,
    MODE_AWAKE    = 2'b10,
    MODE_ALWAYS   = 2'b11
  } wdt_mode_t;

  typedef struct packed {
    logic       enter_sleep;
    logic       exit_sleep;
    logic       in_sleep;
    logic       crystal_clock;
    logic       osc_startup_busy;
    logic       osc_fail;
  } power_events_t;

  typedef struct packed {
    logic       device_reset;
    logic       wake;
    logic       timeout_status_flag;
    logic       powerdown_status_flag;
  } wdt_result_t;
endpackage

/* hw/watchdog_timer_unit.sv */
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "wdt_map.svh"
module watchdog_timer_unit #(
  parameter int TICK_DIV = `WDT_LFOSC_PER_TICK,
  parameter int CNT_W    = 19
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  // Low-frequency oscillator clock, asynchronous
  input  wire logic                   low_freq_internal_osc,
  // Configuration
  input  wire wdt_pkg::wdt_mode_t     watchdog_mode_select,
  input  wire logic                   watchdog_clear_instruction,
  input  wire wdt_pkg::power_events_t power_events,
  // Register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_write,
  input  wire logic                   reg_read,
  output logic      [7:0]             reg_rdata,
  // Results
  output wdt_pkg::wdt_result_t        result
);
  import wdt_pkg::*;

  // -------------------------------------------------------------------------
  // Control register
  // -------------------------------------------------------------------------
  logic [4:0] period_reg;
  logic       enable_reg;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      period_reg <= `WDT_PERIOD_RESET;
      enable_reg <= 1'b0;
    end else if (reg_write && reg_addr == `WDT_CTRL_OFFSET) begin
      period_reg <= reg_wdata[`WDT_PERIOD_MSB:`WDT_PERIOD_LSB];
      enable_reg <= reg_wdata[`WDT_ENABLE_BIT];
    end
  end

  // -------------------------------------------------------------------------
  // Oscillator synchroniser and edge detect
  // -------------------------------------------------------------------------
  // The divider setting of the system oscillator is not an input at all, so
  // its changes cannot disturb the count.
  logic osc_s1_reg;
  logic osc_s2_reg;
  logic osc_s3_reg;
  logic osc_rise;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
    end else begin
      osc_s1_reg <= low_freq_internal_osc;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end

  assign osc_rise = osc_s2_reg && !osc_s3_reg;

  // -------------------------------------------------------------------------
  // Active decode
  // -------------------------------------------------------------------------
  logic active;

  always_comb begin
    case (watchdog_mode_select)
      MODE_OFF:      active = 1'b0;
      MODE_SOFTWARE: active = enable_reg;
      MODE_AWAKE:    active = !power_events.in_sleep;
      default:       active = 1'b1;
    endcase
  end

  // -------------------------------------------------------------------------
  // Counters
  // -------------------------------------------------------------------------
  logic [5:0]       div_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             hold_reg;
  logic             clear;
  logic             tick;
  logic             expire;

  // Hold clear after a crystal-clock wake until the start-up timer ends.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hold_reg <= 1'b0;
    end else if (power_events.exit_sleep && power_events.crystal_clock) begin
      hold_reg <= 1'b1;
    end else if (!power_events.osc_startup_busy) begin
      hold_reg <= 1'b0;
    end
  end

  assign clear = watchdog_clear_instruction || power_events.osc_fail
              || !active
              || power_events.enter_sleep
              || power_events.exit_sleep || hold_reg
              || power_events.osc_startup_busy;
  assign tick   = osc_rise && (div_reg == 6'(TICK_DIV - 1));
  // Timeout after 2^period ticks, at most 2^CNT_W; the tap moves one bit per step up to period CNT_W.
  assign expire = tick && (cnt_reg == CNT_W'((CNT_W'(1) << period_reg) - 1)) && !clear;

  always_ff @(posedge mclk) begin
    if (!nrst || clear) begin
      div_reg <= 6'h00;
      cnt_reg <= '0;
    end else if (osc_rise) begin
      div_reg <= tick ? 6'h00 : div_reg + 6'h01;
      if (tick) begin
        cnt_reg <= expire ? '0 : cnt_reg + CNT_W'(1);
      end
    end
  end

  // -------------------------------------------------------------------------
  // Results and status flags
  // -------------------------------------------------------------------------
  logic reset_reg;
  logic wake_reg;
  logic to_reg;
  logic pd_reg;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reset_reg <= 1'b0;
      wake_reg  <= 1'b0;
    end else begin
      reset_reg <= expire && !power_events.in_sleep;
      wake_reg  <= expire && power_events.in_sleep;
    end
  end

  // Flags are held as the active-low status bits; power-up shows both high.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      to_reg <= 1'b1;
      pd_reg <= 1'b1;
    end else if (expire) begin
      to_reg <= 1'b0;
      pd_reg <= !power_events.in_sleep;
    end else if (power_events.enter_sleep) begin
      to_reg <= 1'b1;
      pd_reg <= 1'b0;
    end
  end

  assign result = '{device_reset: reset_reg, wake: wake_reg,
                    timeout_status_flag: to_reg, powerdown_status_flag: pd_reg};

  // -------------------------------------------------------------------------
  // Read port
  // -------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read && reg_addr == `WDT_CTRL_OFFSET) begin
      reg_rdata <= {2'b00, period_reg, enable_reg};
    end else if (reg_read && reg_addr == `WDT_STAT_OFFSET) begin
      reg_rdata <= {4'h0, active, hold_reg, to_reg, pd_reg};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Ticks since the last clear or timeout, tallied apart from the live counter so the
  // doubling rule is checked against something other than the compare logic.
  logic [31:0] ref_ticks_reg;

  always_ff @(posedge mclk) begin
    if (!nrst || clear || expire) begin
      ref_ticks_reg <= 32'h0000_0000;
    end else if (tick) begin
      ref_ticks_reg <= ref_ticks_reg + 32'h0000_0001;
    end
  end

  // Wake with a crystal clock: the hold must cover the whole start-up time
  sequence s_crystal_wake;
    power_events.exit_sleep && power_events.crystal_clock;
  endsequence

  sequence s_startup_running;
    power_events.osc_startup_busy;
  endsequence

  // A timeout means different things awake and asleep
  sequence s_timeout_awake;
    expire && !power_events.in_sleep;
  endsequence

  sequence s_timeout_asleep;
    expire && power_events.in_sleep;
  endsequence

  chk_off_no_count: assert property (watchdog_mode_select == MODE_OFF |=> cnt_reg == '0)
    else $error("counter moved in mode off");
  chk_always_active: assert property (watchdog_mode_select == MODE_ALWAYS |-> active)
    else $error("always mode not active");
  chk_awake_sleep: assert property (watchdog_mode_select == MODE_AWAKE && power_events.in_sleep |-> !active)
    else $error("awake mode active in sleep");
  chk_sw_enable: assert property (watchdog_mode_select == MODE_SOFTWARE |-> active == enable_reg)
    else $error("software mode ignores enable");
  chk_clear_instr: assert property (watchdog_clear_instruction |=> cnt_reg == '0 && div_reg == 6'h00)
    else $error("clear instruction failed");
  chk_sleep_entry: assert property (power_events.enter_sleep && !expire |=> cnt_reg == '0 && !pd_reg && to_reg)
    else $error("sleep entry effects missing");
  chk_timeout_reset: assert property (expire && !power_events.in_sleep |=> result.device_reset && !result.wake)
    else $error("timeout gave no reset");
  chk_sleep_wake: assert property (expire && power_events.in_sleep |=> result.wake && !result.device_reset)
    else $error("sleep timeout did not wake");
  chk_crystal_hold: assert property (s_crystal_wake ##1 s_startup_running |=> cnt_reg == '0)
    else $error("counter ran during start-up");
  chk_reset_period: assert property ($rose(nrst) |-> period_reg == `WDT_PERIOD_RESET)
    else $error("period not restored");

  // Clearing conditions
  chk_fail_clear: assert property (power_events.osc_fail |=> cnt_reg == '0 && div_reg == 6'h00)
    else $error("oscillator failure did not clear");

  chk_disabled_hold: assert property (!active |=> cnt_reg == '0)
    else $error("counter moved while disabled");

  chk_sleep_clear: assert property (power_events.enter_sleep |=> cnt_reg == '0 && div_reg == 6'h00)
    else $error("sleep entry did not clear");

  chk_wake_clear: assert property (power_events.exit_sleep |=> cnt_reg == '0)
    else $error("sleep exit did not clear");

  chk_hold_running: assert property (hold_reg |=> cnt_reg == '0)
    else $error("counter ran during crystal hold");

  // Counting
  chk_count_still: assert property (!tick && !clear |=> cnt_reg == $past(cnt_reg))
    else $error("counter moved without a tick");

  chk_count_step: assert property (tick && !clear && !expire |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
    else $error("counter missed a tick");

  chk_expire_restart: assert property (expire |=> cnt_reg == '0)
    else $error("counter not restarted after timeout");

  chk_period_double: assert property (expire |-> ref_ticks_reg == (32'h0000_0001 << period_reg) - 32'h0000_0001)
    else $error("timeout length not a power of two");

  // Results and flags
  chk_awake_flags: assert property (s_timeout_awake |=> !to_reg && pd_reg)
    else $error("awake timeout flags wrong");

  chk_asleep_flags: assert property (s_timeout_asleep |=> !to_reg && !pd_reg)
    else $error("sleep timeout flags wrong");

  chk_reset_pulse: assert property (result.device_reset |=> !result.device_reset)
    else $error("reset pulse too long");

  chk_wake_pulse: assert property (result.wake |=> !result.wake)
    else $error("wake pulse too long");

  // Register port
  chk_period_write: assert property (reg_write && reg_addr == `WDT_CTRL_OFFSET
                                     |=> period_reg == $past(reg_wdata[`WDT_PERIOD_MSB:`WDT_PERIOD_LSB]))
    else $error("period write lost");

  chk_read_ctrl: assert property (reg_read && reg_addr == `WDT_CTRL_OFFSET
                                  |=> reg_rdata == {2'b00, $past(period_reg), $past(enable_reg)})
    else $error("control read wrong");
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import wdt_pkg::*;
  // ---------------------------------------------------------------------------
  // Stimulus and observation
  // ---------------------------------------------------------------------------
  logic          mclk       = 1'b0;
  logic          nrst       = 1'b0;
  logic          osc        = 1'b0;
  logic          clr        = 1'b0;
  logic          rd_s       = 1'b0;
  logic          wr_s       = 1'b0;
  logic [7:0]    addr       = 8'h00;
  logic [7:0]    wdata      = 8'h00;
  wdt_mode_t     mode       = MODE_OFF;
  power_events_t pe         = '0;
  logic [7:0]    rdata;
  wdt_result_t   res;
  logic [7:0]    rv;
  logic [1:0]    seen;
  int            t2, t3;
  int            error_cnt  = 0;
  int            n_compared = 0;
  int            cyc        = 0;

  // TICK_DIV of 1 keeps every timeout within a few hundred cycles
  watchdog_timer_unit #(.TICK_DIV(1)) i_watchdog_timer_unit (
    .mclk(mclk), .nrst(nrst), .low_freq_internal_osc(osc), .watchdog_mode_select(mode),
    .watchdog_clear_instruction(clr), .power_events(pe), .reg_addr(addr), .reg_wdata(wdata),
    .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata), .result(res));

  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // Slow clock with an unrelated phase, 20 mclk per period
  initial begin
    #7;
    forever #50 osc = ~osc;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge mclk);
    wr_s  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Waits for a reset or wake pulse; the bound guards against a silent design
  task automatic watch(input int lim, output int t, output logic [1:0] s);
    s = 2'b00;
    t = 0;
    while (t < lim && s == 2'b00) begin
      @(posedge mclk);
      #1;
      t++;
      s = {res.device_reset, res.wake};
    end
  endtask

  function automatic logic [7:0] flags();
    return {6'h00, res.timeout_status_flag, res.powerdown_status_flag};
  endfunction

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    rd(8'h00, rv); chk(rv, 8'h16);
    rd(8'h08, rv); chk(rv, 8'h00);
    rd(8'h04, rv); chk(rv, 8'h03);
    chk(flags(), 8'h03);
    wr(8'h00, 8'h01);
    watch(300, t2, seen); chk({6'h00, seen}, 8'h00);
    @(posedge mclk) mode <= MODE_SOFTWARE;
    wr(8'h00, 8'h00);
    watch(300, t2, seen); chk({6'h00, seen}, 8'h00);
    wr(8'h00, 8'h01);
    watch(300, t2, seen); chk({6'h00, seen}, 8'h02);
    #2; chk(flags(), 8'h01);
    wr(8'h00, 8'h05);
    @(posedge mclk) clr <= 1'b1;
    watch(400, t2, seen); chk({6'h00, seen}, 8'h00);
    @(posedge mclk) clr <= 1'b0;
    watch(400, t2, seen); chk({6'h00, seen}, 8'h02);
    @(posedge mclk) pe.osc_fail <= 1'b1;
    watch(400, t2, seen); chk({6'h00, seen}, 8'h00);
    @(posedge mclk) pe.osc_fail <= 1'b0;
    // Period 2 against period 3: each step doubles the wait
    watch(400, t2, seen);
    watch(400, t2, seen);
    wr(8'h00, 8'h07);
    watch(400, t3, seen);
    watch(400, t3, seen);
    chk({7'h00, t3 > t2 + t2 / 2}, 8'h01);
    @(posedge mclk) mode <= MODE_AWAKE;
    wr(8'h00, 8'h01);
    @(posedge mclk);
    pe.in_sleep    <= 1'b1;
    pe.enter_sleep <= 1'b1;
    @(posedge mclk) pe.enter_sleep <= 1'b0;
    watch(300, t2, seen); chk({6'h00, seen}, 8'h00);
    chk(flags(), 8'h02);
    @(posedge mclk) mode <= MODE_ALWAYS;
    watch(300, t2, seen); chk({6'h00, seen}, 8'h01);
    #2; chk(flags(), 8'h00);
    @(posedge mclk);
    pe.in_sleep         <= 1'b0;
    pe.crystal_clock    <= 1'b1;
    pe.osc_startup_busy <= 1'b1;
    pe.exit_sleep       <= 1'b1;
    @(posedge mclk) pe.exit_sleep <= 1'b0;
    watch(300, t2, seen); chk({6'h00, seen}, 8'h00);
    @(posedge mclk) pe.osc_startup_busy <= 1'b0;
    watch(300, t2, seen); chk({6'h00, seen}, 8'h02);
    report_and_stop();
  end
endmodule
